// ---- design/rcp_pkg.sv ----
// Package of constants and types for the core pipeline control block
package rcp_pkg;
  localparam int unsigned QueueDepth   = 4;
  localparam int unsigned QueuePtrW    = 2;
  localparam int unsigned CacheBytes   = 4096;
  localparam int unsigned CacheWays    = 2;
  localparam int unsigned LineBytes    = 16;
  localparam int unsigned CacheSets    = CacheBytes / (CacheWays * LineBytes);
  localparam int unsigned SetW         = 7;
  localparam int unsigned TagW         = 21;
  localparam int unsigned MulLatency   = 3;
  localparam int unsigned DivLatency   = 8;
  localparam int unsigned WordLoadLat  = 2;
  localparam int unsigned DwordLoadLat = 3;
  localparam int unsigned ImmW         = 16;
  localparam int unsigned PredBit      = 21;
  localparam logic [31:0] ResetPc      = 32'h0000_0100;
  localparam logic [31:0] InstrStep    = 32'h0000_0004;
  localparam logic [31:0] WordStep     = 32'h0000_0004;
  localparam logic [63:0] FloatDefNan  = 64'h7FF8_0000_0000_0000;

  typedef enum logic [3:0] {
    OP_ALU    = 4'h0,
    OP_MUL    = 4'h1,
    OP_DIV    = 4'h2,
    OP_LOAD   = 4'h3,
    OP_STORE  = 4'h4,
    OP_BR     = 4'h5,
    OP_BRC    = 4'h6,
    OP_BRLINK = 4'h7,
    OP_BRCNT  = 4'h8,
    OP_FLOAT  = 4'h9,
    OP_NOP    = 4'hF
  } rcp_op_t;

  typedef enum logic [2:0] {
    SZ_BYTE  = 3'h0,
    SZ_HALF  = 3'h1,
    SZ_HALFA = 3'h2,
    SZ_WORD  = 3'h3,
    SZ_DWORD = 3'h4
  } rcp_size_t;

  typedef enum logic [2:0] {
    LS_IDLE   = 3'b001,
    LS_FIRST  = 3'b010,
    LS_SECOND = 3'b100
  } rcp_ls_state_t;

  // Zero-fills bytes and half-words, sign-extends algebraic half-words
  function automatic logic [31:0] rcp_extend(input rcp_size_t sz, input logic [31:0] raw);
    case (sz)
      SZ_BYTE:  rcp_extend = {24'h00_0000, raw[7:0]};
      SZ_HALF:  rcp_extend = {16'h0000, raw[15:0]};
      SZ_HALFA: rcp_extend = {{16{raw[15]}}, raw[15:0]};
      default:  rcp_extend = raw;
    endcase
  endfunction
endpackage

// ---- design/rcp_icache.sv ----
// Two-way set-associative instruction cache tag store with LRU victim choice
`timescale 1ns/1ps
`default_nettype none
module rcp_icache (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [31:0] lookupAddr,
  input  wire logic        fillValid,
  input  wire logic [31:0] fillAddr,
  output logic             hit
);
  import rcp_pkg::*;

  logic [TagW-1:0] tagQ   [CacheWays][CacheSets];
  logic [TagW-1:0] tagD   [CacheWays][CacheSets];
  logic            validQ [CacheWays][CacheSets];
  logic            validD [CacheWays][CacheSets];
  logic            lruQ   [CacheSets];
  logic            lruD   [CacheSets];
  logic [SetW-1:0] lSet;
  logic [SetW-1:0] fSet;
  logic [1:0]      wayHit;

  assign lSet = lookupAddr[SetW+3:4];
  assign fSet = fillAddr[SetW+3:4];

  genvar w;
  generate
    for (w = 0; w < CacheWays; w++) begin : gWay
      assign wayHit[w] = validQ[w][lSet] && (tagQ[w][lSet] == lookupAddr[31:SetW+4]);
    end
  endgenerate
  assign hit = |wayHit;

  always_comb begin
    tagD   = tagQ;
    validD = validQ;
    lruD   = lruQ;
    if (fillValid) begin
      // Victim is the least recently used way
      tagD[lruQ[fSet]][fSet]   = fillAddr[31:SetW+4];
      validD[lruQ[fSet]][fSet] = 1'b1;
      lruD[fSet]               = ~lruQ[fSet];
    end else if (hit) begin
      lruD[lSet] = ~wayHit[1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int s = 0; s < CacheSets; s++) begin
        validQ[0][s] <= 1'b0;
        validQ[1][s] <= 1'b0;
        tagQ[0][s]   <= '0;
        tagQ[1][s]   <= '0;
        lruQ[s]      <= 1'b0;
      end
    end else begin
      validQ <= validD;
      tagQ   <= tagD;
      lruQ   <= lruD;
    end
  end
endmodule
`default_nettype wire

// ---- design/rcp_muldiv.sv ----
// Multiply/divide unit: pipelined multiply, unpipelined divide held for DivLatency cycles
`timescale 1ns/1ps
`default_nettype none
module rcp_muldiv (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        mulStart,
  input  wire logic        divStart,
  input  wire logic [31:0] opA,
  input  wire logic [31:0] opB,
  output logic             divBusy,
  output logic             resValid,
  output logic [31:0]      result
);
  import rcp_pkg::*;

  logic [MulLatency-1:0] mulVldQ, mulVldD;
  logic [31:0]           mulResQ [MulLatency];
  logic [31:0]           mulResD [MulLatency];
  logic [3:0]            divCntQ, divCntD;
  logic [31:0]           divResQ, divResD;
  logic                  divDoneQ, divDoneD;

  always_comb begin
    // Multiplies advance one stage per cycle, so they may issue back to back
    mulVldD    = {mulVldQ[MulLatency-2:0], mulStart};
    mulResD[0] = opA * opB;
    for (int i = 1; i < MulLatency; i++) begin
      mulResD[i] = mulResQ[i-1];
    end
    divCntD  = divCntQ;
    divResD  = divResQ;
    divDoneD = 1'b0;
    if (divStart && divCntQ == 4'h0) begin
      divCntD = 4'(DivLatency);
      divResD = (opB == 32'h0000_0000) ? 32'h0000_0000 : opA / opB;
    end else if (divCntQ != 4'h0) begin
      divCntD  = divCntQ - 4'h1;
      divDoneD = (divCntQ == 4'h1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mulVldQ  <= '0;
      divCntQ  <= 4'h0;
      divResQ  <= '0;
      divDoneQ <= 1'b0;
      for (int i = 0; i < MulLatency; i++) mulResQ[i] <= '0;
    end else begin
      mulVldQ  <= mulVldD;
      mulResQ  <= mulResD;
      divCntQ  <= divCntD;
      divResQ  <= divResD;
      divDoneQ <= divDoneD;
    end
  end

  assign divBusy  = (divCntQ != 4'h0);
  assign resValid = mulVldQ[MulLatency-1] | divDoneQ;
  assign result   = divDoneQ ? divResQ : mulResQ[MulLatency-1];
endmodule
`default_nettype wire

// ---- design/rcp_core.sv ----
// Issue and execution control of the RISC core pipeline
// Behaviour
// - Logic/add/bit-field unit accepts and executes one instruction every cycle.
// - Fetched instructions buffer in a four-entry prefetch queue scanned by branch unit.
// - Instruction cache is 4 KB, two-way, least-recently-used replacement.
// - Unresolved conditional branch predicted by encoding bit; fetch continues on prediction.
// - Logic-unit results past a predicted branch are held until it resolves; other units complete.
// - Misprediction discards predicted-path instructions and resumes from correct path.
// - Unconditional and unaffected conditional branches folded out without execution slot.
// - Return address saved in link register; link/count branches take targets from link/count register.
// - Multiplies pipelined; they may issue on consecutive cycles.
// - Divides not pipelined; divide or multiply after a divide stalls pipeline.
// - Divide next to a logic/bit-field instruction causes no delay.
// - Load/store stalls stall non-memory issue only on data dependency; a load/store also waits while the unit is busy.
// - Load/store unit accepts any access size back to back.
// - 32-bit integer register path, 64-bit float register path.
// - Word access one clock, latency two; double-word two clocks, latency three.
// - Double-word transfer done as two 32-bit bus accesses.
// - Byte and half-word loads zero-fill; algebraic half-word loads sign-extend.
// - Effective address is base or zero plus index or 16-bit immediate.
// - Default mode: float overflow, underflow, NaN, denormal raise assist exception.
// - Fast mode: such cases return default results without assist exception.
// - History kept to roll back to a precise point on exception.
// - Out-of-order completion appears sequential to the program.
`timescale 1ns/1ps
`default_nettype none
module rcp_core (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                instrValid,
  input  wire logic [31:0]         instrWord,
  input  wire rcp_pkg::rcp_op_t    instrOp,
  input  wire rcp_pkg::rcp_size_t  instrSize,
  input  wire logic                instrUseImm,
  input  wire logic                instrBaseZero,
  input  wire logic                instrCondBusy,
  input  wire logic                instrCondTaken,
  input  wire logic [31:0]         srcA,
  input  wire logic [31:0]         srcB,
  input  wire logic [4:0]          instrDest,
  input  wire logic                branchResolve,
  input  wire logic                branchActual,
  input  wire logic                excRequest,
  input  wire logic                floatFastMode,
  input  wire logic                floatSpecial,
  input  wire logic                busDone,
  input  wire logic [31:0]         busRdata,
  output logic                     fetchReq,
  output logic [31:0]              fetchAddr,
  output logic                     queueReady,
  output logic                     busReq,
  output logic [31:0]              busAddr,
  output logic                     busWrite,
  output logic [31:0]              busWdata,
  output logic                     intWbValid,
  output logic [31:0]              intWbData,
  output logic [4:0]               intWbDest,
  output logic                     floatWbValid,
  output logic [63:0]              floatWbData,
  output logic                     floatAssist,
  output logic                     flush,
  output logic                     stall,
  output logic [31:0]              linkRegister,
  output logic [31:0]              countRegister,
  output logic                     icacheHit
);
  import rcp_pkg::*;

  // Prefetch queue
  logic [31:0]      queueQ [QueueDepth];
  logic [31:0]      queueD [QueueDepth];
  logic [QueuePtrW:0] qCntQ, qCntD;

  logic [31:0] pcQ, pcD, lrQ, lrD, ctrQ, ctrD, savedPcQ, savedPcD;
  logic        specQ, specD, predQ, predD;
  logic [31:0] altPcQ, altPcD;
  logic [31:0] histPcQ, histPcD;
  logic        prevMulDivQ, prevMulDivD, prevDivQ, prevDivD;
  logic        fetchReqQ, flushQ, flushD, stallD;
  logic [MulLatency-1:0] mulPendQ, mulPendD;
  logic [4:0]  mulDestQ [MulLatency], mulDestD [MulLatency], divDestQ, divDestD;
  logic        aluVldQ, aluVldD;
  logic [31:0] aluResQ, aluResD;
  logic [4:0]  aluDestQ, aluDestD;
  logic        heldVldQ, heldVldD;
  logic [31:0] heldResQ, heldResD;
  logic [4:0]  heldDestQ, heldDestD;
  logic        fAssistQ, fAssistD, fVldQ, fVldD;
  logic [63:0] fDataQ, fDataD;

  rcp_ls_state_t lsQ, lsD;
  logic [31:0] lsAddrQ, lsAddrD, lsLoQ, lsLoD;
  logic [4:0]  lsDestQ, lsDestD;
  logic [4:0]  pendDestQ, pendDestD;
  logic        lsDwQ, lsDwD, lsLoadQ, lsLoadD;
  rcp_size_t   lsSizeQ, lsSizeD;
  logic [31:0] lsDataQ, lsDataD;

  logic        mdStartMul, mdStartDiv, mdBusy, mdVld, cacheHit;
  logic [31:0] mdRes, effAddr;
  logic        hazardLs, issue, isMem;

  rcp_icache uIcache (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .lookupAddr(pcQ),
    .fillValid (fetchReqQ && !cacheHit),
    .fillAddr  (pcQ),
    .hit       (cacheHit)
  );

  rcp_muldiv uMulDiv (
    .sys_clk (sys_clk),
    .rst     (rst),
    .mulStart(mdStartMul),
    .divStart(mdStartDiv),
    .opA     (srcA),
    .opB     (srcB),
    .divBusy (mdBusy),
    .resValid(mdVld),
    .result  (mdRes)
  );

  assign isMem   = (instrOp == OP_LOAD) || (instrOp == OP_STORE);
  // Base or zero plus register or sign-extended 16-bit immediate
  assign effAddr = (instrBaseZero ? 32'h0000_0000 : srcA)
                 + (instrUseImm ? {{16{instrWord[ImmW-1]}}, instrWord[ImmW-1:0]} : srcB);
  // Non-memory issue waits on the memory pipeline only when its destination matches the pending load's; a load/store also waits while the unit is busy
  assign hazardLs = (lsQ != LS_IDLE) && lsLoadQ && (instrDest == pendDestQ);
  // Divide or multiply after a divide stalls while the divider is busy; a logic instruction does not
  assign stallD  = instrValid && (hazardLs
                 || (mdBusy && (instrOp == OP_DIV || instrOp == OP_MUL))
                 || (isMem && lsQ != LS_IDLE && !(busDone && (lsQ == LS_SECOND || !lsDwQ))));
  assign issue   = instrValid && !stallD && qCntQ != '0;
  assign mdStartMul = issue && instrOp == OP_MUL;
  assign mdStartDiv = issue && instrOp == OP_DIV;

  always_comb begin
    queueD = queueQ; qCntD = qCntQ; pcD = pcQ; lrD = lrQ; ctrD = ctrQ;
    savedPcD = savedPcQ; specD = specQ; predD = predQ; altPcD = altPcQ;
    histPcD = histPcQ; flushD = 1'b0; prevMulDivD = prevMulDivQ; prevDivD = prevDivQ;
    aluVldD = 1'b0; aluResD = aluResQ; aluDestD = aluDestQ;
    heldVldD = heldVldQ; heldResD = heldResQ; heldDestD = heldDestQ;
    fAssistD = 1'b0; fVldD = 1'b0; fDataD = fDataQ;
    // Destinations follow the multiply pipeline and the divider
    mulPendD = {mulPendQ[MulLatency-2:0], mdStartMul};
    mulDestD[0] = instrDest;
    for (int i = 1; i < MulLatency; i++) mulDestD[i] = mulDestQ[i-1];
    divDestD = mdStartDiv ? instrDest : divDestQ;
    // Fill the queue from the cache while room remains
    if (fetchReqQ && cacheHit && qCntQ < (QueuePtrW+1)'(QueueDepth)) begin
      queueD[qCntQ[QueuePtrW-1:0]] = instrWord;
      qCntD = qCntQ + 1'b1;
      pcD   = pcQ + InstrStep;
    end
    if (issue) begin
      for (int i = 0; i < QueueDepth-1; i++) queueD[i] = queueD[i+1];
      qCntD = qCntD - 1'b1;
      if (!specQ) histPcD = savedPcQ;
      savedPcD = savedPcQ + InstrStep;
      case (instrOp)
        OP_ALU: begin
          // One result per cycle from the logic/bit-field unit
          aluResD = srcA + srcB; aluDestD = instrDest;
          if (specQ) begin
            heldVldD = 1'b1; heldResD = aluResD; heldDestD = instrDest;
          end else aluVldD = 1'b1;
        end
        OP_BR: begin
          // Folded: no execution slot
          lrD = savedPcQ + InstrStep;
          pcD = savedPcQ + {{16{instrWord[ImmW-1]}}, instrWord[ImmW-1:0]};
          qCntD = '0;
        end
        OP_BRLINK: begin pcD = lrQ; qCntD = '0; end
        OP_BRCNT:  begin pcD = ctrQ; ctrD = ctrQ - 32'h0000_0001; qCntD = '0; end
        OP_BRC: begin
          if (!instrCondBusy) begin
            if (instrCondTaken) begin pcD = savedPcQ + srcB; qCntD = '0; end
          end else begin
            // Predict from encoding bit and keep fetching on that path
            specD = 1'b1; predD = instrWord[PredBit];
            altPcD = instrWord[PredBit] ? savedPcQ + InstrStep : savedPcQ + srcB;
            if (instrWord[PredBit]) begin pcD = savedPcQ + srcB; qCntD = '0; end
          end
        end
        OP_FLOAT: begin
          // Assist exception unless fast mode returns a default
          fAssistD = floatSpecial && !floatFastMode;
          fVldD = !(floatSpecial && !floatFastMode);
          fDataD = floatSpecial ? FloatDefNan : {srcA, srcB};
        end
        default: ;
      endcase
      prevMulDivD = instrOp == OP_MUL || instrOp == OP_DIV;
      prevDivD = instrOp == OP_DIV;
    end
    if (specQ && branchResolve) begin
      specD = 1'b0;
      if (branchActual != predQ) begin
        // Discard predicted path and restart at correct one
        flushD = 1'b1; qCntD = '0; pcD = altPcQ; heldVldD = 1'b0;
      end else if (heldVldQ) begin
        aluVldD = 1'b1; aluResD = heldResQ; aluDestD = heldDestQ; heldVldD = 1'b0;
      end
    end
    if (excRequest) begin
      // Roll back to last precise point
      flushD = 1'b1; qCntD = '0; pcD = histPcQ; savedPcD = histPcQ; specD = 1'b0; heldVldD = 1'b0;
    end
  end

  // Load/store pipeline, doubles split into two word accesses
  always_comb begin
    lsD = lsQ; lsAddrD = lsAddrQ; lsLoD = lsLoQ; lsDestD = lsDestQ; lsDwD = lsDwQ;
    lsLoadD = lsLoadQ; lsSizeD = lsSizeQ; lsDataD = lsDataQ; pendDestD = pendDestQ;
    case (lsQ)
      LS_IDLE, LS_SECOND: begin
        if (lsQ == LS_SECOND && !busDone) lsD = LS_SECOND;
        else lsD = LS_IDLE;
      end
      LS_FIRST: begin
        if (busDone) begin
          lsLoD = busRdata;
          if (lsDwQ) begin lsD = LS_SECOND; lsAddrD = lsAddrQ + WordStep; lsDataD = srcA; end
          else lsD = LS_IDLE;
        end
      end
      default: lsD = LS_IDLE;
    endcase
    // Issue is allowed when the unit is idle or frees up this cycle
    if (issue && isMem) begin
      lsD = LS_FIRST; lsAddrD = effAddr; lsDestD = instrDest; pendDestD = instrDest;
      lsDwD = instrSize == SZ_DWORD; lsLoadD = instrOp == OP_LOAD;
      lsSizeD = instrSize; lsDataD = srcB;
    end
  end

  always_ff @(posedge sys_clk) mulDestQ <= mulDestD;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < QueueDepth; i++) queueQ[i] <= '0;
      qCntQ <= '0; pcQ <= ResetPc; lrQ <= '0; ctrQ <= '0;
      savedPcQ <= ResetPc; specQ <= 1'b0; predQ <= 1'b0; altPcQ <= '0;
      histPcQ <= ResetPc; flushQ <= 1'b0; fetchReqQ <= 1'b0;
      prevMulDivQ <= 1'b0; prevDivQ <= 1'b0; mulPendQ <= '0; divDestQ <= '0;
      aluVldQ <= 1'b0; aluResQ <= '0; aluDestQ <= '0;
      heldVldQ <= 1'b0; heldResQ <= '0; heldDestQ <= '0;
      fAssistQ <= 1'b0; fVldQ <= 1'b0; fDataQ <= '0;
      lsQ <= LS_IDLE; lsAddrQ <= '0; lsLoQ <= '0; lsDestQ <= '0;
      pendDestQ <= '0; lsDwQ <= 1'b0; lsLoadQ <= 1'b0; lsSizeQ <= SZ_WORD;
      lsDataQ <= '0; intWbValid <= 1'b0; intWbData <= '0;
      intWbDest <= '0; floatWbValid <= 1'b0; floatWbData <= '0;
      busReq <= 1'b0; busAddr <= '0; busWrite <= 1'b0; busWdata <= '0;
      icacheHit <= 1'b0;
    end else begin
      queueQ <= queueD; qCntQ <= qCntD; pcQ <= pcD; lrQ <= lrD; ctrQ <= ctrD;
      savedPcQ <= savedPcD; specQ <= specD; predQ <= predD; altPcQ <= altPcD;
      histPcQ <= histPcD; flushQ <= flushD;
      mulPendQ <= mulPendD; divDestQ <= divDestD;
      fetchReqQ <= qCntD < (QueuePtrW+1)'(QueueDepth);
      prevMulDivQ <= prevMulDivD; prevDivQ <= prevDivD;
      aluVldQ <= aluVldD; aluResQ <= aluResD; aluDestQ <= aluDestD;
      heldVldQ <= heldVldD; heldResQ <= heldResD; heldDestQ <= heldDestD;
      fAssistQ <= fAssistD; fVldQ <= fVldD; fDataQ <= fDataD;
      lsQ <= lsD; lsAddrQ <= lsAddrD; lsLoQ <= lsLoD; lsDestQ <= lsDestD;
      pendDestQ <= pendDestD; lsDwQ <= lsDwD; lsLoadQ <= lsLoadD; lsSizeQ <= lsSizeD;
      lsDataQ <= lsDataD;
      busReq <= lsD != LS_IDLE;
      busAddr <= lsAddrD;
      busWrite <= !lsLoadD;
      busWdata <= lsDataD;
      // Integer writeback over 32-bit path, extended by access size
      if (lsQ == LS_FIRST && busDone && lsLoadQ && !lsDwQ) begin
        intWbValid <= 1'b1; intWbData <= rcp_extend(lsSizeQ, busRdata); intWbDest <= lsDestQ;
      end else if (aluVldQ) begin
        intWbValid <= 1'b1; intWbData <= aluResQ; intWbDest <= aluDestQ;
      end else begin
        intWbValid <= mdVld; intWbData <= mdRes;
        intWbDest <= mulPendQ[MulLatency-1] ? mulDestQ[MulLatency-1] : divDestQ;
      end
      // Float writeback over 64-bit path
      if (lsQ == LS_SECOND && busDone && lsLoadQ) begin
        floatWbValid <= 1'b1; floatWbData <= {lsLoQ, busRdata};
      end else begin
        floatWbValid <= fVldQ; floatWbData <= fDataQ;
      end
      icacheHit <= cacheHit;
    end
  end

  assign fetchReq      = fetchReqQ;
  assign fetchAddr     = pcQ;
  assign queueReady    = qCntQ != '0;
  assign floatAssist   = fAssistQ;
  assign flush         = flushQ;
  assign stall         = stallD;
  assign linkRegister  = lrQ;
  assign countRegister = ctrQ;
endmodule
`default_nettype wire

// ---- dv/rcp_core_checker.sv ----
// Assertion checker on the core pipeline control ports
`timescale 1ns/1ps
`default_nettype none
module rcp_core_checker
  import rcp_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             rst,
  input wire logic             instrValid,
  input wire logic [31:0]      instrWord,
  input wire rcp_pkg::rcp_op_t instrOp,
  input wire logic             instrCondBusy,
  input wire logic             floatFastMode,
  input wire logic             floatSpecial,
  input wire logic             branchResolve,
  input wire logic             branchActual,
  input wire logic             queueReady,
  input wire logic             stall,
  input wire logic             intWbValid,
  input wire logic             flush,
  input wire logic             floatAssist
);
  logic taken;
  logic specD, specQ, predD, predQ;

  assign taken = instrValid && queueReady && !stall;

  // Tracks an unresolved conditional branch and its predicted direction
  always_comb begin
    specD = branchResolve ? 1'b0 : specQ;
    predD = predQ;
    if (taken && instrOp == OP_BRC && instrCondBusy) begin
      specD = 1'b1;
      predD = instrWord[PredBit];
    end
  end
  always_ff @(posedge sys_clk) begin
    specQ <= rst ? 1'b0 : specD;
    predQ <= predD;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_div_issue;
    taken && instrOp == OP_DIV;
  endsequence
  sequence s_spec_alu;
    specQ && taken && instrOp == OP_ALU && !branchResolve ##1 (!branchResolve)[*2];
  endsequence

  chk_alu_latency: assert property (taken && instrOp == OP_ALU && !specQ |-> ##2 intWbValid)
    else $error("logic unit result missing two cycles after issue");
  chk_mul_latency: assert property (taken && instrOp == OP_MUL |-> ##4 intWbValid)
    else $error("multiply result missing four cycles after issue");
  chk_mul_stream: assert property (taken && instrOp == OP_MUL ##1 instrValid && queueReady && instrOp == OP_MUL |-> !stall)
    else $error("multiply stalled behind multiply");
  chk_div_blocks: assert property (s_div_issue |=> (!(taken && instrOp inside {OP_MUL, OP_DIV}))[*3])
    else $error("divide unit took work while dividing");
  chk_div_alu_free: assert property (s_div_issue ##1 instrValid && queueReady && instrOp == OP_ALU |-> !stall)
    else $error("logic instruction stalled behind divide");
  chk_flush_miss: assert property (branchResolve && specQ && branchActual != predQ |-> ##[1:2] flush)
    else $error("no flush after wrong prediction");
  chk_spec_hold: assert property (s_spec_alu |-> !intWbValid)
    else $error("speculative result completed before branch resolved");
  chk_float_assist: assert property (
    taken && instrOp == OP_FLOAT && floatSpecial && !floatFastMode |-> ##[1:8] floatAssist)
    else $error("no assist for special operand in default mode");
endmodule

bind rcp_core rcp_core_checker u_chk (.*);
`default_nettype wire

// ---- dv/rcp_bus_mem.sv ----
// Load/store bus memory model answering the core's data accesses
`timescale 1ns/1ps
`default_nettype none
module rcp_bus_mem (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        busReq,
  input wire logic [31:0] busAddr,
  input wire logic        memSlow,
  output logic            busDone,
  output logic [31:0]     busRdata
);
  int cnt;
  // Contents are a fixed scramble of the address
  function automatic logic [31:0] word(input logic [31:0] a);
    return {a[15:0] ^ 16'h9A5C, a[31:16] ^ a[15:0]};
  endfunction
  always @(posedge sys_clk) begin
    busDone <= 1'b0;
    busRdata <= ~busRdata;
    if (rst) begin
      cnt <= 0;
      busRdata <= 32'h0000_0000;
    end else if (busReq && !busDone) begin
      if (cnt >= (memSlow ? 2 : 0)) begin
        busDone <= 1'b1;
        busRdata <= word(busAddr);
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the core pipeline control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rcp_pkg::*;
  logic        sys_clk = 1'b0, rst = 1'b1, instrValid = 1'b0, instrUseImm = 1'b0, instrBaseZero = 1'b0;
  logic        instrCondBusy = 1'b0, instrCondTaken = 1'b0, branchResolve = 1'b0, branchActual = 1'b0;
  logic        excRequest = 1'b0, floatFastMode = 1'b0, floatSpecial = 1'b0, memSlow = 1'b0;
  logic        busDone, fetchReq, queueReady, busReq, busWrite, intWbValid, floatWbValid, floatAssist, flush;
  logic        stall, icacheHit;
  logic [31:0] instrWord = 32'h0000_0000, srcA = 32'h0000_0000, srcB = 32'h0000_0000;
  logic [31:0] busRdata, fetchAddr, busAddr, busWdata, intWbData, linkRegister, countRegister, ea;
  logic [4:0]  instrDest = 5'h00, intWbDest;
  logic [63:0] floatWbData;
  rcp_op_t     instrOp = OP_NOP;
  rcp_size_t   instrSize = SZ_WORD;
  int          seed, n_mismatch, n_tests, cyc, k, nFlush, nAssist;
  logic [4:0]  expD[$];
  longint      expV[$];
  logic [31:0] eaQ[$];
  logic [63:0] expF[$];

  rcp_core dut (.*);
  rcp_bus_mem mem (.*);

  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic push(input longint v);
    expD.push_back(instrDest);
    expV.push_back(v);
  endtask

  task automatic put(input rcp_op_t op, input rcp_size_t sz, input logic [31:0] w, a, b);
    int n;
    logic [31:0] r;
    n = 0;
    #1;
    instrOp = op;
    instrSize = sz;
    {instrWord, srcA, srcB, instrDest, instrValid} = {w, a, b, instrDest + 5'h01, 1'b1};
    {instrUseImm, instrBaseZero, memSlow} = 3'(rnd());
    instrCondBusy = (op == OP_BRC);
    floatSpecial = (op == OP_FLOAT);
    floatFastMode = w[0];
    do begin
      @(posedge sys_clk);
      n++;
    end while ((queueReady !== 1'b1 || stall !== 1'b0) && n < 40);
    check("instruction taken", 1, n < 40);
    ea = (instrBaseZero ? 32'h0000_0000 : a) + (instrUseImm ? {16'h0000, w[15:0]} : b);
    case (op)
      OP_ALU: push(32'(a + b));
      OP_MUL: push(32'(a * b));
      OP_DIV: push(a / b);
      OP_FLOAT: if (w[0]) expF.push_back(FloatDefNan);
      OP_LOAD: begin
        r = mem.word(ea);
        eaQ.push_back(ea);
        if (sz == SZ_DWORD) begin
          eaQ.push_back(ea + WordStep);
          expF.push_back({r, mem.word(ea + WordStep)});
        end else push(sz == SZ_BYTE ? {24'h00_0000, r[7:0]} : sz == SZ_HALF ? {16'h0000, r[15:0]} :
                      sz == SZ_HALFA ? {{16{r[15]}}, r[15:0]} : r);
      end
      default: ;
    endcase
  endtask

  task automatic endTest(input string name);
    #1;
    instrValid = 1'b0;
    repeat (16) @(posedge sys_clk);
    check("pending results", 0, expV.size() + expF.size() + eaQ.size());
    $display("test %s done", name);
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      finish_test();
    end
  end

  always @(posedge sys_clk) if (!rst) begin
    nFlush += (flush === 1'b1);
    nAssist += (floatAssist === 1'b1);
    if (busReq === 1'b1 && busDone === 1'b1) begin
      if (eaQ.size() == 0) check("busReq", 0, 1);
      else check("busAddr", eaQ.pop_front(), busAddr);
    end
    if (floatWbValid === 1'b1) begin
      if (expF.size() == 0) check("floatWbValid", 0, 1);
      else check("floatWbData", expF.pop_front(), floatWbData);
    end
    if (intWbValid === 1'b1) begin
      k = -1;
      foreach (expD[i]) if (expD[i] === intWbDest && k < 0) k = i;
      check("intWbValid", 1, k >= 0);
      if (k >= 0 && expV[k] >= 0) check("intWbData", expV[k], intWbData);
      if (k >= 0) expD.delete(k);
      if (k >= 0) expV.delete(k);
    end
  end

  initial begin
    seed = 9;
    repeat (3) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    check("fetchAddr", ResetPc, fetchAddr);
    @(posedge sys_clk);
    for (int i = 0; i < 12; i++) put(i < 6 ? OP_ALU : OP_MUL, SZ_WORD, rnd(), rnd(), rnd());
    endTest("logic and multiply streams");
    put(OP_DIV, SZ_WORD, rnd(), rnd() & 32'h7FFF_FFFF, rnd() | 32'h0000_0001);
    put(OP_ALU, SZ_WORD, rnd(), rnd(), rnd());
    put(OP_MUL, SZ_WORD, rnd(), rnd() & 32'h7FFF_FFFF, rnd() | 32'h0000_0001);
    put(OP_DIV, SZ_WORD, rnd(), rnd() & 32'h7FFF_FFFF, rnd() | 32'h0000_0001);
    endTest("divide neighbours");
    for (int i = 0; i < 15; i++) put(OP_LOAD, rcp_size_t'(i % 5), rnd() & 32'h0000_7FF8, rnd() & 32'hFFFF_FFF8, rnd() & 32'hFFFF_FFF8);
    endTest("loads of every size");
    put(OP_BR, SZ_WORD, 32'h0000_0000, rnd(), rnd());
    put(OP_ALU, SZ_WORD, rnd(), rnd(), rnd());
    for (int p = 0; p < 4; p++) begin
      put(OP_BRC, SZ_WORD, 32'(p >> 1) << PredBit, rnd(), rnd());
      put(OP_ALU, SZ_WORD, rnd(), rnd(), rnd());
      if ((p >> 1) != (p & 1)) expD.pop_back();
      if ((p >> 1) != (p & 1)) expV.pop_back();
      #1;
      instrValid = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      {branchResolve, branchActual} = {1'b1, 1'(p)};
      @(posedge sys_clk);
      #1;
      branchResolve = 1'b0;
      endTest("branch prediction");
    end
    check("flush count", 2, nFlush);
    put(OP_FLOAT, SZ_DWORD, 32'h0000_0000, rnd(), rnd());
    put(OP_FLOAT, SZ_DWORD, 32'h0000_0001, rnd(), rnd());
    endTest("float special operands");
    check("assist count", 1, nAssist);
    finish_test();
  end
endmodule
`default_nettype wire
